// file: design/gpp_bus_if.sv
// Interface carrying register port signals between the top and its decoder.
`timescale 1ns/100ps
interface gpp_bus_if;
    import gpp_pkg::*;
    logic [GPP_AW-1:0] addr;
    logic              wr;
    logic              rd;
    logic [GPP_DW-1:0] wdata;
    logic [11:0]       wr_hit;
    logic [11:0]       rd_hit;

    modport top (
        output addr,
        output wr,
        output rd,
        output wdata,
        input  wr_hit,
        input  rd_hit
    );
    modport dec (
        input  addr,
        input  wr,
        input  rd,
        output wr_hit,
        output rd_hit
    );
endinterface

// file: design/gpp_decode.sv
// Address decoder producing one-hot register select strobes.
`timescale 1ns/100ps
module gpp_decode
    import gpp_pkg::*;
(
    gpp_bus_if.dec bus
);
    // ************************************************************
    // One-hot decode of the word index
    // ************************************************************
    always_comb begin
        bus.wr_hit = 12'h000;
        bus.rd_hit = 12'h000;
        if (bus.addr <= GPP_WAKE_OFS) begin
            bus.wr_hit[bus.addr] = bus.wr;
            bus.rd_hit[bus.addr] = bus.rd;
        end
    end
endmodule

// file: design/gpp_pkg.sv
// Package of constants and types for the general-purpose pad port.
package gpp_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int GPP_NPADS = 17;
    localparam int GPP_AW    = 4;
    localparam int GPP_DW    = 32;
    // Index of the sleep-wake pad, which offers pull-down, not pull-up.
    localparam int GPP_SLEEP_WAKE_PAD = 16;

    typedef logic [GPP_NPADS-1:0] gpp_vec_t;

    // ************************************************************
    // Register offsets (word index on the register port)
    // ************************************************************
    localparam logic [GPP_AW-1:0] GPP_OUT_OFS    = 4'h0;
    localparam logic [GPP_AW-1:0] GPP_OE_OFS     = 4'h1;
    localparam logic [GPP_AW-1:0] GPP_IN_OFS     = 4'h2;
    localparam logic [GPP_AW-1:0] GPP_PULL_OFS   = 4'h3;
    localparam logic [GPP_AW-1:0] GPP_ALT_OFS    = 4'h4;
    localparam logic [GPP_AW-1:0] GPP_TRIG_OFS   = 4'h5;
    localparam logic [GPP_AW-1:0] GPP_POL_OFS    = 4'h6;
    localparam logic [GPP_AW-1:0] GPP_IEN_OFS    = 4'h7;
    localparam logic [GPP_AW-1:0] GPP_STAT_OFS   = 4'h8;
    localparam logic [GPP_AW-1:0] GPP_MASK_OFS   = 4'h9;
    localparam logic [GPP_AW-1:0] GPP_HOLD_OFS   = 4'ha;
    localparam logic [GPP_AW-1:0] GPP_WAKE_OFS   = 4'hb;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam gpp_vec_t GPP_VEC_RST  = 17'h00000;
    localparam gpp_vec_t GPP_MASK_RST = 17'h1ffff;

    // Wake-enable bit inside the wake control register.
    localparam int GPP_WAKE_EN_BIT = 0;

endpackage

// file: design/gpp_port.sv
// Seventeen-pad general-purpose I/O port with interrupts, hold and wake.
// Contract
// - Seventeen pins; software assigns each pin's function through registers.
// - Per-pad pull-up or high impedance; sleep-wake pad offers pull-down only.
// - Input pin levels are captured into a software-readable register.
// - Each input raises an interrupt; software selects edge or level.
// - Pads are bidirectional, non-inverting, tristate with per-pad enable.
// - Each pin may carry an alternate peripheral function instead.
// - With hold on in low power, outputs keep their pre-entry value.
// - An external pin interrupt wakes the chip from light sleep.
`timescale 1ns/100ps
module gpp_port
    import gpp_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              clk_en_i,
    input  wire logic [GPP_AW-1:0] reg_addr_i,
    input  wire logic [GPP_DW-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [GPP_DW-1:0] reg_rdata_o,
    input  wire logic [16:0]       pad_in_i,
    output logic      [16:0]       pad_out_o,
    output logic      [16:0]       pad_oe_o,
    output logic      [16:0]       pad_pu_o,
    output logic      [16:0]       pad_pd_o,
    input  wire logic [16:0]       alt_out_i,
    input  wire logic [16:0]       alt_oe_i,
    output logic      [16:0]       alt_in_o,
    input  wire logic              low_power_i,
    output logic                   wake_o,
    output logic                   irq_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        gpp_vec_t          out;
        gpp_vec_t          oe;
        gpp_vec_t          pull;
        gpp_vec_t          alt;
        gpp_vec_t          trig;
        gpp_vec_t          pol;
        gpp_vec_t          ien;
        gpp_vec_t          stat;
        gpp_vec_t          mask;
        gpp_vec_t          hold;
        logic              wake_en;
        gpp_vec_t          in_s;
        gpp_vec_t          in_d;
        gpp_vec_t          held_out;
        gpp_vec_t          held_oe;
        logic              lp_d;
        gpp_vec_t          pad_out;
        gpp_vec_t          pad_oe;
        gpp_vec_t          pad_pu;
        gpp_vec_t          pad_pd;
        gpp_vec_t          alt_in;
        logic [GPP_DW-1:0] rdata;
        logic              wake;
        logic              irq;
    } gpp_state_s;

    gpp_state_s st_r;
    gpp_state_s st_nxt;

    gpp_bus_if bus ();

    assign bus.addr  = reg_addr_i;
    assign bus.wr    = reg_wr_i;
    assign bus.rd    = reg_rd_i;
    assign bus.wdata = reg_wdata_i;

    gpp_decode u_dec (
        .bus (bus)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    gpp_vec_t wv;
    gpp_vec_t hit_ev;
    gpp_vec_t drv_out;
    gpp_vec_t drv_oe;
    gpp_vec_t stat_new;
    logic     enter_lp;

    always_comb begin
        st_nxt   = st_r;
        wv       = bus.wdata[GPP_NPADS-1:0];
        // Input capture for software and peripherals.
        st_nxt.in_s   = pad_in_i;
        st_nxt.in_d   = st_r.in_s;
        st_nxt.alt_in = pad_in_i;
        // Edge when trig bit set, else level; pol picks rising/high.
        for (int i = 0; i < GPP_NPADS; i++) begin
            if (st_r.trig[i]) begin
                hit_ev[i] = st_r.pol[i]
                    ? (st_r.in_s[i] & ~st_r.in_d[i])
                    : (~st_r.in_s[i] & st_r.in_d[i]);
            end else begin
                hit_ev[i] = ~(st_r.in_s[i] ^ st_r.pol[i]);
            end
        end
        hit_ev = hit_ev & st_r.ien & ~st_r.oe;
        // Write-one clears, but a new event in the same cycle wins.
        stat_new = st_r.stat;
        if (bus.wr_hit[GPP_STAT_OFS]) begin
            stat_new = stat_new & ~wv;
        end
        stat_new    = stat_new | hit_ev;
        st_nxt.stat = stat_new;

        // Register writes configure each pin's function.
        if (bus.wr_hit[GPP_OUT_OFS])  st_nxt.out  = wv;
        if (bus.wr_hit[GPP_OE_OFS])   st_nxt.oe   = wv;
        if (bus.wr_hit[GPP_PULL_OFS]) st_nxt.pull = wv;
        if (bus.wr_hit[GPP_ALT_OFS])  st_nxt.alt  = wv;
        if (bus.wr_hit[GPP_TRIG_OFS]) st_nxt.trig = wv;
        if (bus.wr_hit[GPP_POL_OFS])  st_nxt.pol  = wv;
        if (bus.wr_hit[GPP_IEN_OFS])  st_nxt.ien  = wv;
        if (bus.wr_hit[GPP_MASK_OFS]) st_nxt.mask = wv;
        if (bus.wr_hit[GPP_HOLD_OFS]) st_nxt.hold = wv;
        if (bus.wr_hit[GPP_WAKE_OFS]) begin
            st_nxt.wake_en = bus.wdata[GPP_WAKE_EN_BIT];
        end

        // Alternate function replaces the register-driven value.
        drv_out = (st_r.alt & alt_out_i) | (~st_r.alt & st_r.out);
        drv_oe  = (st_r.alt & alt_oe_i)  | (~st_r.alt & st_r.oe);

        // Snapshot drive on entry to low power; held pads keep it.
        st_nxt.lp_d = low_power_i;
        enter_lp    = low_power_i & ~st_r.lp_d;
        if (enter_lp) begin
            st_nxt.held_out = drv_out;
            st_nxt.held_oe  = drv_oe;
        end
        if (low_power_i) begin
            drv_out = (st_r.hold & (enter_lp ? drv_out : st_r.held_out))
                    | (~st_r.hold & drv_out);
            drv_oe  = (st_r.hold & (enter_lp ? drv_oe : st_r.held_oe))
                    | (~st_r.hold & drv_oe);
        end
        // Non-inverting tristate driver per pad.
        st_nxt.pad_out = drv_out;
        st_nxt.pad_oe  = drv_oe;
        // Pull-up on all pads but the sleep-wake pad, which pulls down.
        st_nxt.pad_pu = st_r.pull;
        st_nxt.pad_pu[GPP_SLEEP_WAKE_PAD] = 1'b0;
        st_nxt.pad_pd = '0;
        st_nxt.pad_pd[GPP_SLEEP_WAKE_PAD] = st_r.pull[GPP_SLEEP_WAKE_PAD];

        st_nxt.irq  = |(stat_new & ~st_r.mask);
        // Pin interrupt in low power requests wake-up.
        st_nxt.wake = st_r.wake_en & low_power_i & |(stat_new & ~st_r.mask);

        // ********************************************************
        // Read port: data valid the cycle after the strobe.
        // ********************************************************
        st_nxt.rdata = '0;
        case (1'b1)
            bus.rd_hit[GPP_OUT_OFS]:  st_nxt.rdata[16:0] = st_r.out;
            bus.rd_hit[GPP_OE_OFS]:   st_nxt.rdata[16:0] = st_r.oe;
            bus.rd_hit[GPP_IN_OFS]:   st_nxt.rdata[16:0] = st_r.in_s;
            bus.rd_hit[GPP_PULL_OFS]: st_nxt.rdata[16:0] = st_r.pull;
            bus.rd_hit[GPP_ALT_OFS]:  st_nxt.rdata[16:0] = st_r.alt;
            bus.rd_hit[GPP_TRIG_OFS]: st_nxt.rdata[16:0] = st_r.trig;
            bus.rd_hit[GPP_POL_OFS]:  st_nxt.rdata[16:0] = st_r.pol;
            bus.rd_hit[GPP_IEN_OFS]:  st_nxt.rdata[16:0] = st_r.ien;
            bus.rd_hit[GPP_STAT_OFS]: st_nxt.rdata[16:0] = st_r.stat;
            bus.rd_hit[GPP_MASK_OFS]: st_nxt.rdata[16:0] = st_r.mask;
            bus.rd_hit[GPP_HOLD_OFS]: st_nxt.rdata[16:0] = st_r.hold;
            bus.rd_hit[GPP_WAKE_OFS]: st_nxt.rdata[0]    = st_r.wake_en;
            default:                  st_nxt.rdata       = '0;
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r      <= '0;
            st_r.mask <= GPP_MASK_RST;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign pad_out_o   = st_r.pad_out;
    assign pad_oe_o    = st_r.pad_oe;
    assign pad_pu_o    = st_r.pad_pu;
    assign pad_pd_o    = st_r.pad_pd;
    assign alt_in_o    = st_r.alt_in;
    assign wake_o      = st_r.wake;
    assign irq_o       = st_r.irq;

endmodule

// file: sim/gpp_pad_port_test.sv
// Self-checking bench of the pad port.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module gpp_pad_port_test;
    import gpp_pkg::*;
    logic              clk_i = 1'b0, sys_rst_i = 1'b1, low_power_i = 1'b0;
    logic              reg_wr_i = 1'b0, reg_rd_i = 1'b0, wake_o, irq_o;
    logic              clk_en_i = 1'b1;
    logic [GPP_AW-1:0] reg_addr_i = 4'h0;
    logic [GPP_DW-1:0] reg_wdata_i = 32'h0, reg_rdata_o;
    gpp_vec_t          pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, pad_pd_o;
    gpp_vec_t          alt_in_o, alt_out_i = 17'h0, alt_oe_i = 17'h0;
    gpp_vec_t          ext_val = 17'h0, ext_en = 17'h0;
    int                n_fail = 0, comparisons = 0, cycles = 0;
    gpp_port uut (.clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pad_in_i,
        .pad_out_o, .pad_oe_o, .pad_pu_o, .pad_pd_o, .alt_out_i, .alt_oe_i,
        .alt_in_o, .low_power_i, .wake_o, .irq_o);
    gpp_pad_world ext (.clk_i, .out_i(pad_out_o), .oe_i(pad_oe_o),
        .pu_i(pad_pu_o), .pd_i(pad_pd_o), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .pad_o(pad_in_i));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK("rdata", e, reg_rdata_o)
    endtask
    task automatic t_regs();
        wr(4'hc, 32'hffffffff);
        for (int a = 0; a < 16; a++) begin
            if (a != 2) rdc(4'(a), (a == 9) ? 32'h1ffff : 32'h0);
        end
    endtask
    task automatic t_drive();
        wr(GPP_OUT_OFS, 32'h15555);
        wr(GPP_OE_OFS, 32'h1ffff);
        cyc(3);
        `CHK("pad_out", 17'h15555, pad_out_o)
        `CHK("pad_oe", 17'h1ffff, pad_oe_o)
        rdc(GPP_IN_OFS, 32'h15555);
    endtask
    task automatic t_pull();
        wr(GPP_OE_OFS, 32'h0);
        wr(GPP_PULL_OFS, 32'h1ffff);
        cyc(3);
        `CHK("pad_pu", 17'h0ffff, pad_pu_o)
        `CHK("pad_pd", 17'h10000, pad_pd_o)
        rdc(GPP_IN_OFS, 32'h0ffff);
        wr(GPP_PULL_OFS, 32'h0);
    endtask
    task automatic t_alt();
        @(posedge clk_i) alt_out_i <= 17'h0a5a5;
        alt_oe_i <= 17'h1ffff;
        wr(GPP_ALT_OFS, 32'h1ffff);
        cyc(3);
        `CHK("pad_out", 17'h0a5a5, pad_out_o)
        `CHK("alt_in", 17'h0a5a5, alt_in_o)
        wr(GPP_ALT_OFS, 32'h0);
        cyc(3);
        `CHK("pad_oe", 17'h0, pad_oe_o)
    endtask
    task automatic t_irq();
        @(posedge clk_i) ext_en <= 17'h1ffff;
        wr(GPP_TRIG_OFS, 32'h1);
        wr(GPP_POL_OFS, 32'h1);
        wr(GPP_MASK_OFS, 32'h1fffe);
        wr(GPP_IEN_OFS, 32'h1);
        @(posedge clk_i) ext_val <= 17'h1;
        cyc(4);
        `CHK("irq", 1'b1, irq_o)
        @(posedge clk_i) ext_val <= 17'h0;
        cyc(4);
        rdc(GPP_STAT_OFS, 32'h1);
        `CHK("irq", 1'b1, irq_o)
        wr(GPP_STAT_OFS, 32'h1);
        cyc(3);
        `CHK("irq", 1'b0, irq_o)
        wr(GPP_TRIG_OFS, 32'h0);
        @(posedge clk_i) ext_val <= 17'h1;
        cyc(4);
        wr(GPP_STAT_OFS, 32'h1);
        cyc(3);
        `CHK("irq", 1'b1, irq_o)
        @(posedge clk_i) low_power_i <= 1'b1;
        wr(GPP_WAKE_OFS, 32'h1);
        cyc(3);
        `CHK("wake", 1'b1, wake_o)
        wr(GPP_MASK_OFS, 32'h1ffff);
        cyc(3);
        `CHK("irq", 1'b0, irq_o)
        `CHK("wake", 1'b0, wake_o)
        @(posedge clk_i) low_power_i <= 1'b0;
        wr(GPP_WAKE_OFS, 32'h0);
    endtask
    task automatic t_hold();
        wr(GPP_OE_OFS, 32'h1ffff);
        wr(GPP_OUT_OFS, 32'h1ffff);
        wr(GPP_HOLD_OFS, 32'h1ffff);
        @(posedge clk_i) low_power_i <= 1'b1;
        wr(GPP_OUT_OFS, 32'h0);
        cyc(3);
        `CHK("pad_out", 17'h1ffff, pad_out_o)
        @(posedge clk_i) low_power_i <= 1'b0;
        cyc(3);
        `CHK("pad_out", 17'h0, pad_out_o)
    endtask
    task automatic t_freeze();
        @(posedge clk_i) clk_en_i <= 1'b0;
        wr(GPP_OUT_OFS, 32'h0aaaa);
        cyc(3);
        `CHK("pad_out", 17'h0, pad_out_o)
        @(posedge clk_i) clk_en_i <= 1'b1;
        cyc(3);
        `CHK("pad_out", 17'h0, pad_out_o)
        rdc(GPP_OUT_OFS, 32'h0);
    endtask
    task automatic t_reset();
        @(posedge clk_i) sys_rst_i <= 1'b1;
        cyc(2);
        `CHK("pad_oe", 17'h0, pad_oe_o)
        `CHK("irq", 1'b0, irq_o)
        @(posedge clk_i) sys_rst_i <= 1'b0;
        rdc(GPP_MASK_OFS, 32'h1ffff);
        rdc(GPP_OE_OFS, 32'h0);
    endtask
    task automatic results();
        if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_drive();
        t_pull();
        t_alt();
        t_irq();
        t_hold();
        t_freeze();
        t_reset();
        results();
    end
endmodule

// file: sim/gpp_pad_world.sv
// Model of the external circuits attached to the pads.
`timescale 1ns/100ps
module gpp_pad_world
    import gpp_pkg::*;
(
    input  wire logic     clk_i,
    input  wire gpp_vec_t out_i,
    input  wire gpp_vec_t oe_i,
    input  wire gpp_vec_t pu_i,
    input  wire gpp_vec_t pd_i,
    input  wire gpp_vec_t ext_val_i,
    input  wire gpp_vec_t ext_en_i,
    output gpp_vec_t      pad_o
);
    // A pad nobody drives and nothing pulls flips level every cycle.
    gpp_vec_t flt_r = 17'h00000;
    always_ff @(posedge clk_i) begin
        flt_r <= ~flt_r;
    end
    assign pad_o = (oe_i & out_i)
        | (~oe_i & ext_en_i & ext_val_i)
        | (~oe_i & ~ext_en_i & (pu_i | (~pd_i & flt_r)));
endmodule

// file: sim/gpp_port_chk.sv
// Checker of the port-level relations of the pad port.
`timescale 1ns/100ps
module gpp_port_chk
    import gpp_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              sys_rst_i,
    input wire logic              clk_en_i,
    input wire logic [GPP_AW-1:0] reg_addr_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [GPP_DW-1:0] reg_rdata_o,
    input wire logic [16:0]       pad_in_i,
    input wire logic [16:0]       pad_pu_o,
    input wire logic [16:0]       pad_pd_o,
    input wire logic [16:0]       alt_in_o,
    input wire logic              low_power_i,
    input wire logic              wake_o,
    input wire logic              irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    pu_sleep_a: assert property (pad_pu_o[16] == 1'b0)
        else $error("pull-up on the sleep-wake pad");
    pd_plain_a: assert property (pad_pd_o[15:0] == 16'h0000)
        else $error("pull-down on a plain pad");
    pull_cause_a: assert property ($changed({pad_pu_o, pad_pd_o}) |->
        $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
        else $error("pull changed without a write");
    rdata_idle_a: assert property ($past(clk_en_i) && !$past(reg_rd_i)
        |-> reg_rdata_o == 32'h0) else $error("read data outside slot");
    rdata_width_a: assert property (reg_rdata_o[31:17] == 15'h0000)
        else $error("read data above pad width");
    unmapped_a: assert property ($past(reg_rd_i) && $past(clk_en_i)
        && $past(reg_addr_i) >= 4'hc
        |-> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
    irq_sticky_a: assert property ($fell(irq_o) |-> $past(reg_wr_i) ||
        $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
        else $error("interrupt dropped without a write");
    wake_sleep_a: assert property (wake_o |-> $past(low_power_i))
        else $error("wake outside low power");
    alt_in_a: assert property (!$past(sys_rst_i) && $past(clk_en_i)
        |-> alt_in_o == $past(pad_in_i))
        else $error("peripheral input not tracking pins");
    cover property ($rose(irq_o));
    cover property ($rose(wake_o));
    cover property (reg_rd_i && reg_addr_i >= 4'hc);
endmodule
bind gpp_port gpp_port_chk chk (.clk_i, .sys_rst_i, .clk_en_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pad_in_i, .pad_pu_o, .pad_pd_o,
    .alt_in_o, .low_power_i, .wake_o, .irq_o);
